/* logic/asrpc_ctrl.sv */
// Contract
// R01: Once mode runs the scan one time per start, then idles.
// R02: Triggered mode is once mode without needing to re-arm the trigger.
// R03: Looping restarts on completion; parallel converters restart independently. Here only without simultaneous; with it, either completion restarts both.
// R04: Running loop ignores starts and triggers unless paused.
// R05: Loop ends only by halt bit, never by completion.
// R06: Triggers ignored during a scan unless paused.
// R07: Once mode keeps ignoring triggers until trigger-arm is set again.
// R08: Arm bits re-arm trigger inputs A and B at any time.
// R09: Software changes clock settings only with both converters powered down.
// R10: Normal mode: conversion clock always, no power-up delay.
// R11: Auto-standby: powered, auto-powerdown clear, auto-standby set, clock enabled.
// R12: Standby clock is master oscillator divided by 80, 100 kHz.
// R13: Auto-standby uses conversion clock active, standby clock and low current idle.
// R14: Auto-standby inserts power-up delay at every scan start.
// R15: Auto-powerdown: powered, auto-powerdown set, clock enabled; conversion clock active.
// R16: Auto-powerdown gates clock and powers down converters when idle.
// R17: Auto-powerdown inserts power-up delay at every scan start.
// R18: Standby mode runs continuously at 100 kHz in standby current, no delay.
// R19: Standby mode unavailable with an external oscillator source.
// R20: Hybrid: 100 kHz standby current active, gated and off idle, delay.
// R21: Powerdown: both converters down and clock enable clear shuts everything.
// R22: Reset leaves reference and both converters powered down.
// R23: Starts during the power-up delay are ignored.
// R24: Scan starts on start write or armed trigger rising edge.
// R25: Power mode decided from inputs, applied only while both converters idle.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module asrpc_ctrl
	import asrpc_pkg::*;
#(
	parameter int DIV_W = 8,
	parameter int DLY_W = 12
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic module_clock_enable,
	input wire logic osc_source_select,
	input wire logic internal_osc_standby,
	input wire logic internal_osc_off,
	input wire logic master_osc_tick,
	input wire logic trigger_input_a,
	input wire logic trigger_input_b,
	input wire logic scan_done_a,
	input wire logic scan_done_b,
	output logic scan_start_a,
	output logic scan_start_b,
	output logic scan_busy_a,
	output logic scan_busy_b,
	output logic unit_clk_en,
	output logic conv_a_pd,
	output logic conv_b_pd,
	output logic vref_pd,
	output logic standby_current
);
	logic awv_q, awv_d, wv_q, wv_d, awr_q, awr_d, wr_q, wr_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] ws_q, ws_d;
	logic bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0] mode_q [2];
	logic [1:0] mode_d [2];
	logic [1:0] halt_q, halt_d, pause_q, pause_d, pd_q, pd_d;
	logic par_q, par_d, sim_q, sim_d, apd_q, apd_d, asb_q, asb_d;
	logic [DIV_W-1:0] cdiv_q, cdiv_d;
	logic [DLY_W-1:0] pud_q, pud_d;
	logic [1:0] start_wr, arm_wr;
	logic do_wr;
	asrpc_scan_e st_q [2];
	asrpc_scan_e st_d [2];
	logic [1:0] arm_q, arm_d, trg_q, trg_d, go_d, go_q, busy_d, busy_q, clr, acc_once;
	logic wake_req, indep, dly_done, conv_tick, sb_tick;
	asrpc_pmode_e pm_q, pm_d;
	asrpc_pwr_s pwr_q, pwr_d;
	logic [1:0] psts;

	assign indep = par_q && !sim_q;

	asrpc_div #(.W(DIV_W)) u_conv_div (
		.core_clk(core_clk),
		.srst(srst),
		.in_en(1'b1),
		.div(cdiv_q),
		.out_en(conv_tick)
	);

	// Standby clock: master oscillator over 80 [R12]
	asrpc_div #(.W(7)) u_sby_div (
		.core_clk(core_clk),
		.srst(srst),
		.in_en(master_osc_tick),
		.div(STBY_DIV),
		.out_en(sb_tick)
	);

	asrpc_pud #(.W(DLY_W)) u_pud (
		.core_clk(core_clk),
		.srst(srst),
		.start(wake_req),
		.tick(pwr_d.clk_en),
		.count(pud_q),
		.done(dly_done)
	);

	// Bus slave and configuration registers
	always_comb
	begin
		logic [31:0] w;
		w = wmerge('0, wd_q, ws_q);
		awv_d = awv_q | (s_axi_awvalid & awr_q);
		wv_d = wv_q | (s_axi_wvalid & wr_q);
		awa_d = (s_axi_awvalid & awr_q) ? s_axi_awaddr : awa_q;
		wd_d = (s_axi_wvalid & wr_q) ? s_axi_wdata : wd_q;
		ws_d = (s_axi_wvalid & wr_q) ? s_axi_wstrb : ws_q;
		bv_d = bv_q & ~s_axi_bready;
		br_d = br_q;
		mode_d = mode_q;
		halt_d = halt_q;
		pause_d = pause_q;
		pd_d = pd_q;
		par_d = par_q;
		sim_d = sim_q;
		apd_d = apd_q;
		asb_d = asb_q;
		cdiv_d = cdiv_q;
		pud_d = pud_q;
		start_wr = '0;
		arm_wr = '0;
		do_wr = awv_q && wv_q && !bv_q;
		if (do_wr)
		begin
			awv_d = 1'b0;
			wv_d = 1'b0;
			bv_d = 1'b1;
			br_d = AXI_OKAY;
			case (awa_q)
				OFS_FIRST_CONTROL_REG:
				begin
					w = wmerge({25'h0000000, sim_q, par_q, mode_q[0], 1'b0, halt_q[0], 1'b0},
						wd_q, ws_q);
					start_wr[0] = w[CTL_START];
					arm_wr[0] = w[CTL_ARM]; // [R08]
					halt_d[0] = w[CTL_HALT];
					mode_d[0] = w[CTL_MODE +: 2];
					par_d = w[CTL_PAR];
					sim_d = w[CTL_SIMULT];
				end
				OFS_SECOND_CONTROL_REG:
				begin
					w = wmerge({(32-CTL_DIV-DIV_W)'(0), cdiv_q, 3'h0, mode_q[1], 1'b0,
						halt_q[1], 1'b0}, wd_q, ws_q);
					start_wr[1] = w[CTL_START];
					arm_wr[1] = w[CTL_ARM]; // [R08]
					halt_d[1] = w[CTL_HALT];
					mode_d[1] = w[CTL_MODE +: 2];
					cdiv_d = w[CTL_DIV +: DIV_W];
				end
				OFS_PAUSE:
					pause_d = wd_q[1:0] & {2{ws_q[0]}} | pause_q & ~{2{ws_q[0]}};
				OFS_PWR:
				begin
					w = wmerge({(32-PWR_PUD-DLY_W)'(0), pud_q, asb_q, apd_q, pd_q},
						wd_q, ws_q);
					pd_d = w[PWR_PD +: 2];
					apd_d = w[PWR_APD];
					asb_d = w[PWR_ASB];
					pud_d = w[PWR_PUD +: DLY_W];
				end
				OFS_STAT:
					br_d = AXI_OKAY;
				default:
					br_d = AXI_SLVERR;
			endcase
		end
		awr_d = !awv_d;
		wr_d = !wv_d;
		rv_d = rv_q & ~s_axi_rready;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_arvalid && arr_q)
		begin
			rv_d = 1'b1;
			rr_d = AXI_OKAY;
			case (s_axi_araddr)
				OFS_FIRST_CONTROL_REG:
					rd_d = 32'({sim_q, par_q, mode_q[0], arm_q[0], halt_q[0], 1'b0});
				OFS_SECOND_CONTROL_REG:
					rd_d = 32'({cdiv_q, 3'h0, mode_q[1], arm_q[1], halt_q[1], 1'b0});
				OFS_PAUSE:
					rd_d = 32'(pause_q);
				OFS_PWR:
					rd_d = 32'({psts, pud_q, asb_q, apd_q, pd_q});
				OFS_STAT:
					rd_d = 32'({arm_q, pm_q, busy_q});
				default:
				begin
					rd_d = '0;
					rr_d = AXI_SLVERR;
				end
			endcase
		end
		arr_d = !rv_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			{awv_q, wv_q, bv_q, rv_q} <= '0;
			{awr_q, wr_q, arr_q} <= '0;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			br_q <= AXI_OKAY;
			rr_q <= AXI_OKAY;
			rd_q <= '0;
			mode_q <= '{RST_MODE, RST_MODE};
			halt_q <= '0;
			pause_q <= '0;
			pd_q <= RST_PD; // [R22]
			{par_q, sim_q, apd_q, asb_q} <= '0;
			cdiv_q <= RST_DIV;
			pud_q <= RST_PUD;
		end
		else
		begin
			{awv_q, wv_q, bv_q, rv_q} <= {awv_d, wv_d, bv_d, rv_d};
			{awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			br_q <= br_d;
			rr_q <= rr_d;
			rd_q <= rd_d;
			mode_q <= mode_d;
			halt_q <= halt_d;
			pause_q <= pause_d;
			pd_q <= pd_d;
			{par_q, sim_q, apd_q, asb_q} <= {par_d, sim_d, apd_d, asb_d};
			cdiv_q <= cdiv_d;
			pud_q <= pud_d;
		end
	end

	// Scan engines, one per converter; B follows A unless independent parallel
	always_comb
	begin
		int o;
		asrpc_smode_e m;
		logic edg, acc, go, done;
		o = 0;
		m = SM_ONCE;
		{edg, acc, go, done} = '0;
		st_d = st_q;
		trg_d = {trigger_input_b, trigger_input_a};
		go_d = '0;
		clr = '0;
		acc_once = '0;
		wake_req = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			o = (i == 1 && indep) ? 1 : 0;
			m = asrpc_smode_e'(mode_q[o]);
			edg = trg_d[o] & ~trg_q[o];
			acc = arm_q[o] & edg;
			go = start_wr[o] | acc; // [R24]
			done = indep ? (i == 0 ? scan_done_a : scan_done_b) :
				(scan_done_a | (par_q & scan_done_b));
			case (st_q[i])
				SC_IDLE:
					if (go && !halt_q[o] && pm_q != PM_OFF)
					begin
						if (needs_delay(pm_q)) // [R14] [R17] [R20]
						begin
							st_d[i] = SC_WAKE;
							wake_req = 1'b1;
						end
						else
						begin
							st_d[i] = SC_RUN; // [R10] [R18]
							go_d[i] = 1'b1;
						end
						clr[o] = acc && m != SM_TRIG && m != SM_LOOP; // [R07] [R02]
						acc_once[i] = clr[o];
					end
				SC_WAKE:
					if (halt_q[o])
						st_d[i] = SC_IDLE;
					else if (dly_done) // [R23]
					begin
						st_d[i] = SC_RUN;
						go_d[i] = 1'b1;
					end
				SC_RUN:
					if (halt_q[o])
						st_d[i] = SC_IDLE; // [R05]
					else if (pause_q[o] && go) // [R04] [R06]
					begin
						go_d[i] = 1'b1;
						clr[o] = acc && m != SM_TRIG && m != SM_LOOP;
					end
					else if (done)
					begin
						if (m == SM_LOOP)
							go_d[i] = 1'b1; // [R03]
						else
							st_d[i] = SC_IDLE; // [R01]
					end
				default:
					st_d[i] = SC_IDLE;
			endcase
		end
		for (int j = 0; j < 2; j++)
		begin
			busy_d[j] = st_d[j] != SC_IDLE;
			arm_d[j] = (arm_q[j] & ~clr[j]) | arm_wr[j]; // [R08]
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			st_q <= '{SC_IDLE, SC_IDLE};
			arm_q <= '0;
			trg_q <= '0;
			go_q <= '0;
			busy_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			arm_q <= arm_d;
			trg_q <= trg_d;
			go_q <= go_d;
			busy_q <= busy_d;
		end
	end

	// Power mode selection and unit clock source
	always_comb
	begin
		logic act;
		act = st_q[0] != SC_IDLE || st_q[1] != SC_IDLE;
		pm_d = act ? pm_q : pm_decode(pd_q, apd_q, asb_q, module_clock_enable, // [R25]
			osc_source_select, internal_osc_standby, internal_osc_off); // [R19] [R21]
		pwr_d = '0;
		case (pm_q)
			PM_NORMAL:
				pwr_d.clk_en = conv_tick; // [R10]
			PM_AUTO_SB:
			begin
				pwr_d.clk_en = act ? conv_tick : sb_tick; // [R11] [R13]
				pwr_d.sby = !act;
			end
			PM_AUTO_PD:
				pwr_d.clk_en = act & conv_tick; // [R15] [R16]
			PM_STANDBY:
			begin
				pwr_d.clk_en = sb_tick; // [R18]
				pwr_d.sby = 1'b1;
			end
			PM_HYBRID:
			begin
				pwr_d.clk_en = act & sb_tick; // [R20]
				pwr_d.sby = act;
			end
			default:
				pwr_d.clk_en = 1'b0; // [R21]
		endcase
		for (int k = 0; k < 2; k++)
			pwr_d.conv_pd[k] = pd_q[k] || pm_q == PM_OFF ||
				((pm_q == PM_AUTO_PD || pm_q == PM_HYBRID) && st_q[k] == SC_IDLE); // [R16]
		pwr_d.vref_pd = &pd_q || pm_q == PM_OFF; // [R22]
		for (int k = 0; k < 2; k++)
			psts[k] = pwr_q.conv_pd[k] || st_q[k] == SC_WAKE;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pm_q <= PM_OFF;
			pwr_q <= '{clk_en: 1'b0, conv_pd: RST_PD, vref_pd: 1'b1, sby: 1'b0}; // [R22]
		end
		else
		begin
			pm_q <= pm_d;
			pwr_q <= pwr_d;
		end
	end

	assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awr_q, wr_q, arr_q};
	assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid} = {bv_q, br_q, rv_q};
	assign {s_axi_rdata, s_axi_rresp} = {rd_q, rr_q};
	assign {scan_start_b, scan_start_a, scan_busy_b, scan_busy_a} = {go_q, busy_q};
	assign {unit_clk_en, conv_b_pd, conv_a_pd} = {pwr_q.clk_en, pwr_q.conv_pd};
	assign {vref_pd, standby_current} = {pwr_q.vref_pd, pwr_q.sby};

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	AST_RESET_PD: assert property (disable iff (1'b0) srst |=> conv_a_pd && conv_b_pd && vref_pd) // [R22]
		else $error("converters not powered down after reset");
	AST_ONCE_END: assert property (st_q[0] == SC_RUN && mode_q[0] == 2'h0 && !halt_q[0]
		&& !pause_q[0] && scan_done_a |=> st_q[0] == SC_IDLE ##1 !scan_busy_a) // [R01]
		else $error("once scan did not end");
	AST_LOOP_RESTART: assert property (st_q[0] == SC_RUN && mode_q[0] == 2'h2 && !halt_q[0]
		&& scan_done_a |=> scan_start_a && st_q[0] == SC_RUN) // [R03]
		else $error("loop did not restart");
	AST_RUN_IGNORE: assert property (st_q[0] == SC_RUN && !pause_q[0] && !scan_done_a
		|=> !scan_start_a) // [R04]
		else $error("start taken while running");
	AST_HALT: assert property (halt_q[0] |=> st_q[0] == SC_IDLE ##1 !scan_busy_a) // [R05]
		else $error("halt did not stop converter A");
	AST_ARM_SET: assert property (arm_wr[0] |=> arm_q[0]) // [R08]
		else $error("arm write lost");
	AST_ONCE_DISARM: assert property (acc_once[0] && !arm_wr[0] |=> !arm_q[0]) // [R07]
		else $error("once mode kept trigger armed");
	AST_TRIG_KEEP: assert property (st_q[0] == SC_IDLE && mode_q[0] == 2'h1 && arm_q[0]
		&& go_d[0] |=> arm_q[0]) // [R02]
		else $error("triggered mode disarmed");
	AST_WAKE_HOLD: assert property (st_q[0] == SC_WAKE && !dly_done |=> !scan_start_a) // [R23]
		else $error("scan started during power-up delay");
	AST_AUTOPD_IDLE: assert property (pm_q == PM_AUTO_PD && st_q[0] == SC_IDLE
		|=> conv_a_pd && !unit_clk_en) // [R16]
		else $error("auto-powerdown idle converter not off");
	AST_STANDBY: assert property (pm_q == PM_STANDBY |=> standby_current) // [R18]
		else $error("standby current missing");
	AST_PM_HOLD: assert property (scan_busy_a |-> pm_q == $past(pm_q)) // [R25]
		else $error("power mode changed during a scan");

	COV_LOOP: cover property (st_q[0] == SC_RUN && mode_q[0] == 2'h2 && scan_done_a);
	COV_WAKE: cover property (st_q[0] == SC_WAKE ##[1:200] scan_start_a);
	COV_INDEP: cover property (indep && scan_busy_a && !scan_busy_b);
endmodule
`default_nettype wire

/* logic/asrpc_div.sv */
`timescale 1ns/100ps
`default_nettype none
module asrpc_div
	import asrpc_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic in_en,
	input wire logic [W-1:0] div,
	output logic out_en
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	// One output pulse per div input pulses; div of zero acts as one
	always_comb
	begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (in_en)
		begin
			if (({1'b0, cnt_q} + (W+1)'(1)) >= {1'b0, div})
			begin
				cnt_d = '0;
				tick_d = 1'b1;
			end
			else
				cnt_d = cnt_q + W'(1);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign out_en = tick_q;
endmodule
`default_nettype wire

/* logic/asrpc_pkg.sv */
`default_nettype none
package asrpc_pkg;
	localparam logic [7:0] OFS_FIRST_CONTROL_REG = 8'h00;
	localparam logic [7:0] OFS_SECOND_CONTROL_REG = 8'h04;
	localparam logic [7:0] OFS_PAUSE = 8'h08;
	localparam logic [7:0] OFS_PWR = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam int CTL_START = 0;
	localparam int CTL_HALT = 1;
	localparam int CTL_ARM = 2;
	localparam int CTL_MODE = 3;
	localparam int CTL_PAR = 5;
	localparam int CTL_SIMULT = 6;
	localparam int CTL_DIV = 8;
	localparam int PWR_PD = 0;
	localparam int PWR_APD = 2;
	localparam int PWR_ASB = 3;
	localparam int PWR_PUD = 4;
	localparam int PWR_PSTS = 16;
	localparam int STA_BUSY = 0;
	localparam int STA_PM = 2;
	localparam int STA_ARM = 5;
	localparam logic [1:0] RST_PD = 2'h3;
	localparam logic [11:0] RST_PUD = 12'h0FF;
	localparam logic [7:0] RST_DIV = 8'h01;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam int MOSC_KHZ = 8000;
	localparam int STBY_KHZ = 100;
	localparam logic [6:0] STBY_DIV = 7'(MOSC_KHZ / STBY_KHZ);
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {SM_ONCE, SM_TRIG, SM_LOOP} asrpc_smode_e;
	typedef enum logic [1:0] {SC_IDLE, SC_WAKE, SC_RUN} asrpc_scan_e;
	typedef enum logic [2:0] {PM_OFF, PM_NORMAL, PM_AUTO_SB, PM_AUTO_PD, PM_STANDBY,
		PM_HYBRID} asrpc_pmode_e;

	typedef struct packed {
		logic clk_en;
		logic [1:0] conv_pd;
		logic vref_pd;
		logic sby;
	} asrpc_pwr_s;

	function automatic asrpc_pmode_e pm_decode(input logic [1:0] pd, input logic auto_powerdown_en,
		input logic auto_standby_en, input logic mce, input logic ext, input logic osb, input logic ooff);
		logic sbycfg;
		sbycfg = !ext && osb && !ooff && !auto_standby_en;
		if (&pd || !mce)
			return PM_OFF;
		else if (auto_powerdown_en)
			return sbycfg ? PM_HYBRID : PM_AUTO_PD;
		else if (auto_standby_en)
			return PM_AUTO_SB;
		else
			return sbycfg ? PM_STANDBY : PM_NORMAL;
	endfunction

	function automatic logic needs_delay(input asrpc_pmode_e pm);
		return pm == PM_AUTO_SB || pm == PM_AUTO_PD || pm == PM_HYBRID;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		return r;
	endfunction
endpackage
`default_nettype wire

/* logic/asrpc_pud.sv */
`timescale 1ns/100ps
`default_nettype none
module asrpc_pud
	import asrpc_pkg::*;
#(
	parameter int W = 12
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic tick,
	input wire logic [W-1:0] count,
	output logic done
);
	logic busy_q;
	logic busy_d;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic done_q;
	logic done_d;

	// Counts unit clock ticks of the power-up delay
	always_comb
	begin
		busy_d = busy_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (!busy_q)
		begin
			if (start)
			begin
				busy_d = 1'b1;
				cnt_d = count;
			end
		end
		else if (tick)
		begin
			if (cnt_q <= W'(1))
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			busy_q <= busy_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule
`default_nettype wire

/* tb/asrpc_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module asrpc_ctrl_tb_top;
	import asrpc_pkg::*;
	logic core_clk, srst;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic module_clock_enable, osc_source_select, internal_osc_standby, internal_osc_off;
	logic master_osc_tick, trigger_input_a, trigger_input_b, scan_done_a, scan_done_b;
	logic scan_start_a, scan_start_b, scan_busy_a, scan_busy_b, unit_clk_en;
	logic conv_a_pd, conv_b_pd, vref_pd, standby_current;
	int num_errors, samples_checked, starts_a, starts_b;
	logic [31:0] rd_d;
	logic [1:0] rsp;
	localparam int P_TRG_A = 0;
	localparam int P_DONE_A = 1;
	localparam int P_DONE_B = 2;

	asrpc_ctrl #(.DIV_W(8), .DLY_W(12)) asrpc_ctrl_i (.core_clk(core_clk), .srst(srst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.module_clock_enable(module_clock_enable), .osc_source_select(osc_source_select),
		.internal_osc_standby(internal_osc_standby), .internal_osc_off(internal_osc_off),
		.master_osc_tick(master_osc_tick), .trigger_input_a(trigger_input_a),
		.trigger_input_b(trigger_input_b), .scan_done_a(scan_done_a), .scan_done_b(scan_done_b),
		.scan_start_a(scan_start_a), .scan_start_b(scan_start_b), .scan_busy_a(scan_busy_a),
		.scan_busy_b(scan_busy_b), .unit_clk_en(unit_clk_en), .conv_a_pd(conv_a_pd),
		.conv_b_pd(conv_b_pd), .vref_pd(vref_pd), .standby_current(standby_current));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Master oscillator ticks every second cycle, 10 MHz equivalent
	always @(posedge core_clk)
	begin
		master_osc_tick <= srst ? 1'b0 : ~master_osc_tick;
		if (scan_start_a === 1'b1)
			starts_a <= starts_a + 1;
		if (scan_start_b === 1'b1)
			starts_b <= starts_b + 1;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
		while (s_axi_bvalid !== 1'b1)
			@(posedge core_clk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge core_clk);
		rd_d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic pm(input logic [2:0] e);
		rd(OFS_STAT);
		chk(32'(rd_d[STA_PM +: 3]), 32'(e));
	endtask

	// Waits for a new start pulse on converter A and checks the count and latency bound
	task automatic expect_start(input int base, input int lo, input int hi);
		int lat;
		lat = 0;
		while (starts_a == base && lat < 300)
		begin
			@(posedge core_clk);
			lat++;
		end
		chk(32'(starts_a), 32'(base + 1));
		chk(32'(lat >= lo && lat <= hi), 32'h1);
	endtask

	task automatic pulse(input int sel, input int n);
		@(posedge core_clk);
		case (sel)
			P_TRG_A: trigger_input_a <= 1'b1;
			P_DONE_A: scan_done_a <= 1'b1;
			default: scan_done_b <= 1'b1;
		endcase
		repeat (n) @(posedge core_clk);
		{trigger_input_a, scan_done_a, scan_done_b} <= 3'h0;
		idle(3);
	endtask

	task automatic t_reset();
		chk({conv_a_pd, conv_b_pd, vref_pd}, 32'h7);
		rd(OFS_PWR);
		chk(rd_d & 32'h0000FFFF, 32'h00000FF3);
		rd(8'h20);
		chk(rd_d, 32'h0);
		chk(32'(rsp), 32'(AXI_SLVERR));
	endtask

	task automatic t_once();
		int b;
		wr(OFS_PWR, 32'h00000020);
		for (int i = 0; i < 300 && conv_a_pd !== 1'b0; i++)
			@(posedge core_clk);
		chk(conv_a_pd, 32'h0);
		pm(3'h1);
		b = starts_a;
		wr(OFS_FIRST_CONTROL_REG, 32'h00000001);
		expect_start(b, 0, 3);
		chk(scan_busy_a, 32'h1);
		wr(OFS_FIRST_CONTROL_REG, 32'h00000001);
		idle(10);
		chk(32'(starts_a), 32'(b + 1));
		pulse(P_DONE_A, 1);
		idle(10);
		chk({scan_busy_a, 31'(starts_a)}, {1'b0, 31'(b + 1)});
	endtask

	task automatic t_trig();
		int b;
		b = starts_a;
		wr(OFS_FIRST_CONTROL_REG, 32'h00000004);
		pulse(P_TRG_A, 2);
		chk(32'(starts_a), 32'(b + 1));
		pulse(P_TRG_A, 2);
		chk(32'(starts_a), 32'(b + 1));
		pulse(P_DONE_A, 1);
		pulse(P_TRG_A, 2);
		chk(32'(starts_a), 32'(b + 1));
		wr(OFS_FIRST_CONTROL_REG, 32'h00000004);
		pulse(P_TRG_A, 2);
		chk(32'(starts_a), 32'(b + 2));
		pulse(P_DONE_A, 1);
		wr(OFS_FIRST_CONTROL_REG, 32'h0000000C);
		for (int i = 0; i < 2; i++)
		begin
			pulse(P_TRG_A, 2);
			pulse(P_DONE_A, 1);
		end
		chk(32'(starts_a), 32'(b + 4));
	endtask

	task automatic t_loop();
		int b;
		int c;
		b = starts_a;
		wr(OFS_FIRST_CONTROL_REG, 32'h00000011);
		expect_start(b, 0, 3);
		pulse(P_DONE_A, 1);
		chk(32'(starts_a), 32'(b + 2));
		wr(OFS_FIRST_CONTROL_REG, 32'h00000011);
		idle(5);
		chk({scan_busy_a, 31'(starts_a)}, {1'b1, 31'(b + 2)});
		wr(OFS_FIRST_CONTROL_REG, 32'h00000030);
		wr(OFS_SECOND_CONTROL_REG, 32'h00000111);
		b = starts_a;
		c = starts_b;
		idle(5);
		pulse(P_DONE_B, 1);
		chk(32'(starts_a), 32'(b));
		chk(32'(starts_b), 32'(c + 1));
		wr(OFS_SECOND_CONTROL_REG, 32'h00000102);
		wr(OFS_FIRST_CONTROL_REG, 32'h00000012);
		idle(10);
		chk({scan_busy_a, scan_busy_b}, 32'h0);
		wr(OFS_FIRST_CONTROL_REG, 32'h00000000);
		wr(OFS_SECOND_CONTROL_REG, 32'h00000100);
	endtask

	task automatic t_power();
		int b;
		int n;
		wr(OFS_PWR, 32'h00000088);
		idle(5);
		pm(3'h2);
		chk(standby_current, 32'h1);
		for (int i = 0; i < 400 && unit_clk_en !== 1'b1; i++)
			@(posedge core_clk);
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (unit_clk_en !== 1'b1 && n < 400);
		chk(32'(n), 32'(2 * STBY_DIV));
		b = starts_a;
		wr(OFS_FIRST_CONTROL_REG, 32'h00000001);
		expect_start(b, 8, 290);
		chk(standby_current, 32'h0);
		pulse(P_DONE_A, 1);
		wr(OFS_PWR, 32'h00000084);
		idle(5);
		pm(3'h3);
		chk(conv_a_pd, 32'h1);
		b = starts_a;
		wr(OFS_FIRST_CONTROL_REG, 32'h00000001);
		expect_start(b, 8, 290);
		chk(conv_a_pd, 32'h0);
		pulse(P_DONE_A, 1);
		wr(OFS_PWR, 32'h00000023);
		osc_source_select <= 1'b0;
		internal_osc_standby <= 1'b1;
		wr(OFS_PWR, 32'h00000020);
		idle(5);
		pm(3'h4);
		chk(standby_current, 32'h1);
		wr(OFS_PWR, 32'h00000024);
		idle(5);
		pm(3'h5);
		chk(conv_a_pd, 32'h1);
		wr(OFS_PWR, 32'h00000023);
		osc_source_select <= 1'b1;
		wr(OFS_PWR, 32'h00000020);
		idle(5);
		pm(3'h1);
		wr(OFS_PWR, 32'h00000023);
		module_clock_enable <= 1'b0;
		idle(5);
		pm(3'h0);
		n = 0;
		repeat (20)
		begin
			@(posedge core_clk);
			n += (unit_clk_en !== 1'b0);
		end
		chk(32'(n), 32'h0);
	endtask

	initial
	begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{module_clock_enable, osc_source_select} = 2'h3;
		{internal_osc_standby, internal_osc_off, master_osc_tick} = '0;
		{trigger_input_a, trigger_input_b, scan_done_a, scan_done_b} = '0;
		{num_errors, samples_checked, starts_a, starts_b} = '0;
		srst = 1'b1;
		idle(2);
		srst <= 1'b0;
		idle(2);
		t_reset();
		t_once();
		t_trig();
		t_loop();
		t_power();
		wrap_up();
	end

	initial
	begin
		idle(20000);
		num_errors++;
		$display("timeout at %0t", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
